// File: rate_limiter.sv
// policy constants package and the per-port bandwidth limiter
`timescale 1ns/1ps
package switch_policy_pkg;
    // ==========================================================
    // port and frame geometry
    localparam int         NUM_PORTS     = 8;
    localparam int         PORT_IDX_W    = 3;
    localparam int         LEN_W         = 11;
    localparam int         COST_W        = 15;
    localparam int         BITS_PER_BYTE = 8;
    localparam logic [7:0] GIG_PORT_MASK = 8'hc0;
    localparam logic [7:0] ALL_PORTS     = 8'hff;
    localparam logic [7:0] NO_PORTS      = 8'h00;
    // ==========================================================
    // rate limits in kbps, credit and burst sizes in bits
    localparam int                RATE_W        = 18;
    localparam logic [RATE_W-1:0] RATE_OFF      = 18'h00000;
    localparam logic [RATE_W-1:0] RATE_MIN_KBPS = 18'h00064;
    localparam logic [RATE_W-1:0] RATE_FE_KBPS  = 18'h19000;
    localparam logic [RATE_W-1:0] RATE_GE_KBPS  = 18'h3e800;
    localparam int                CREDIT_W      = 20;
    localparam logic [CREDIT_W-1:0] CREDIT_ZERO = 20'h00000;
    localparam logic [CREDIT_W-1:0] BURST_BITS  = 20'h02f70;
    // ==========================================================
    // refill tick: one kbps equals one bit per millisecond
    localparam int CLK_FREQ_MHZ   = 10;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_FREQ_MHZ;
    localparam int TICK_W         = 24;
    // ==========================================================
    // modes
    typedef enum logic [1:0] {
        VLAN_DISABLED,
        VLAN_PORT_BASED,
        VLAN_TAG_BASED
    } vlan_mode_t;
    typedef enum logic [1:0] {
        CLASS_ALL,
        CLASS_BC_MC_FLOOD,
        CLASS_BC_MC,
        CLASS_BC_ONLY
    } ingress_class_t;
    localparam int         VLAN_GROUPS  = 256;
    localparam int         VLAN_IDX_W   = 8;
endpackage

module rate_limiter
    import switch_policy_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    // refill and limit
    input  wire logic                tick,
    input  wire logic [RATE_W-1:0]   rateKbps,
    // frame charge
    input  wire logic [COST_W-1:0]   costBits,
    input  wire logic                consume,
    output logic                     admit
);
    logic [CREDIT_W-1:0] credit_reg;
    logic [CREDIT_W-1:0] credit_next;
    logic [CREDIT_W-1:0] ceiling;
    logic [CREDIT_W-1:0] sum;

    // zero limit never blocks
    assign admit = (rateKbps == RATE_OFF) ||
                   (credit_reg >= CREDIT_W'(costBits));

    always_comb begin
        ceiling     = CREDIT_W'(rateKbps) + BURST_BITS;
        sum         = credit_reg + CREDIT_W'(rateKbps);
        credit_next = credit_reg;
        if (rateKbps == RATE_OFF) begin
            credit_next = CREDIT_ZERO;
        end else begin
            if (tick) begin
                credit_next = (sum > ceiling) ? ceiling : sum;
            end
            if (consume && admit) begin
                credit_next = credit_next - CREDIT_W'(costBits);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            credit_reg <= CREDIT_ZERO;
        end else begin
            credit_reg <= credit_next;
        end
    end
endmodule

// File: switch_policy.sv
// frame policy: mirroring, rate limiting, port-based vlan and port disable
`timescale 1ns/1ps
module switch_policy
    import switch_policy_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rstn,
    // port state
    input  wire logic [NUM_PORTS-1:0]           portEnable,
    // mirroring setup
    input  wire logic                           mirrorSplit,
    input  wire logic [PORT_IDX_W-1:0]          mirrorRxDest,
    input  wire logic [PORT_IDX_W-1:0]          mirrorTxDest,
    input  wire logic [NUM_PORTS-1:0]           mirrorRxSrc,
    input  wire logic [NUM_PORTS-1:0]           mirrorTxSrc,
    // rate limiting setup
    input  wire logic [NUM_PORTS-1:0][1:0]      ingressClass,
    input  wire logic [NUM_PORTS-1:0][RATE_W-1:0] ingressRateKbps,
    input  wire logic [NUM_PORTS-1:0][RATE_W-1:0] egressRateKbps,
    // vlan setup
    input  wire logic                           vlanModeWr,
    input  wire logic [1:0]                     vlanModeIn,
    input  wire logic                           vlanGroupWr,
    input  wire logic [VLAN_IDX_W-1:0]          vlanGroupId,
    input  wire logic                           vlanGroupValid,
    input  wire logic [NUM_PORTS-1:0]           vlanGroupMembers,
    // frame descriptor in
    input  wire logic                           frmValid,
    input  wire logic [PORT_IDX_W-1:0]          frmSrcPort,
    input  wire logic [NUM_PORTS-1:0]           frmDstMask,
    input  wire logic                           frmBcast,
    input  wire logic                           frmMcast,
    input  wire logic                           frmFlood,
    input  wire logic                           frmTagged,
    input  wire logic [LEN_W-1:0]               frmLenBytes,
    // decision out
    output logic                                outValid,
    output logic [NUM_PORTS-1:0]                outFwdMask,
    output logic [NUM_PORTS-1:0]                outMirrorMask,
    output logic                                outDropped,
    output logic [1:0]                          vlanModeOut
);
    // ==========================================================
    // functions
    function automatic logic classMatch(input logic [1:0] cls, input logic bc,
                                        input logic mc, input logic fl);
        logic hit;
        hit = 1'b0;
        unique case (ingress_class_t'(cls))
            CLASS_ALL:         hit = 1'b1;
            CLASS_BC_MC_FLOOD: hit = bc | mc | fl;
            CLASS_BC_MC:       hit = bc | mc;
            CLASS_BC_ONLY:     hit = bc;
        endcase
        return hit;
    endfunction

    function automatic logic [RATE_W-1:0] clampRate(input logic [RATE_W-1:0] r,
                                                    input logic gig);
        logic [RATE_W-1:0] top;
        top = gig ? RATE_GE_KBPS : RATE_FE_KBPS;
        if (r == RATE_OFF) begin
            return RATE_OFF;
        end else if (r < RATE_MIN_KBPS) begin
            return RATE_MIN_KBPS;
        end else if (r > top) begin
            return top;
        end
        return r;
    endfunction

    function automatic logic [NUM_PORTS-1:0] portBit(input logic [PORT_IDX_W-1:0] p);
        return NUM_PORTS'(1) << p;
    endfunction

    // ==========================================================
    // refill tick divider
    logic [TICK_W-1:0] tickCnt_reg;
    logic [TICK_W-1:0] tickCnt_next;
    logic              tick;

    always_comb begin
        tick         = (tickCnt_reg == TICK_W'(TICK_CYCLES_P - 1));
        tickCnt_next = tick ? '0 : tickCnt_reg + TICK_W'(1);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tickCnt_next;
        end
    end

    // ==========================================================
    // limiters, one per port and direction
    logic [NUM_PORTS-1:0] ingAllow;
    logic [NUM_PORTS-1:0] egAllow;
    logic [NUM_PORTS-1:0] ingConsume;
    logic [NUM_PORTS-1:0] egConsume;
    logic [COST_W-1:0]    cost;

    assign cost = COST_W'(frmLenBytes) * COST_W'(BITS_PER_BYTE);

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_lim
        rate_limiter u_ing (
            .sys_clk  (sys_clk),
            .rstn     (rstn),
            .tick     (tick),
            .rateKbps (clampRate(ingressRateKbps[p], GIG_PORT_MASK[p])),
            .costBits (cost),
            .consume  (ingConsume[p]),
            .admit    (ingAllow[p])
        );
        rate_limiter u_eg (
            .sys_clk  (sys_clk),
            .rstn     (rstn),
            .tick     (tick),
            .rateKbps (clampRate(egressRateKbps[p], GIG_PORT_MASK[p])),
            .costBits (cost),
            .consume  (egConsume[p]),
            .admit    (egAllow[p])
        );
    end

    // ==========================================================
    // vlan mode and membership table
    vlan_mode_t           vlanMode_reg;
    vlan_mode_t           vlanMode_next;
    logic [NUM_PORTS-1:0] groupMask_reg [VLAN_GROUPS];
    logic [NUM_PORTS-1:0] groupMask_next [VLAN_GROUPS];
    logic [VLAN_GROUPS-1:0] groupValid_reg;
    logic [VLAN_GROUPS-1:0] groupValid_next;

    always_comb begin
        vlanMode_next   = vlanMode_reg;
        groupMask_next  = groupMask_reg;
        groupValid_next = groupValid_reg;
        if (vlanModeWr) begin
            vlanMode_next = vlan_mode_t'(vlanModeIn);
        end
        if (vlanGroupWr) begin
            groupValid_next[vlanGroupId] = vlanGroupValid;
            groupMask_next[vlanGroupId]  = vlanGroupMembers;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            vlanMode_reg   <= VLAN_DISABLED;
            groupValid_reg <= '0;
            for (int g = 0; g < VLAN_GROUPS; g++) begin
                groupMask_reg[g] <= NO_PORTS;
            end
        end else begin
            vlanMode_reg   <= vlanMode_next;
            groupValid_reg <= groupValid_next;
            groupMask_reg  <= groupMask_next;
        end
    end

    // ==========================================================
    // per-frame decision
    logic [NUM_PORTS-1:0] srcBit;
    logic [NUM_PORTS-1:0] covered;
    logic [NUM_PORTS-1:0] peers;
    logic [NUM_PORTS-1:0] vlanAllow;
    logic [NUM_PORTS-1:0] fwd;
    logic [NUM_PORTS-1:0] fwdFinal;
    logic [NUM_PORTS-1:0] mirror;
    logic                 srcOk;
    logic                 classHit;
    logic                 ingOk;
    logic                 rxCopy;
    logic                 txCopy;

    always_comb begin
        srcBit  = portBit(frmSrcPort);
        covered = NO_PORTS;
        peers   = NO_PORTS;
        for (int g = 0; g < VLAN_GROUPS; g++) begin
            if (groupValid_reg[g]) begin
                covered = covered | groupMask_reg[g];
                if ((groupMask_reg[g] & srcBit) != NO_PORTS) begin
                    peers = peers | groupMask_reg[g];
                end
            end
        end
        if (vlanMode_reg == VLAN_PORT_BASED) begin
            // frmTagged is deliberately not consulted here
            vlanAllow = ((covered & srcBit) != NO_PORTS) ? peers : ~covered;
        end else begin
            vlanAllow = ALL_PORTS;
        end
        srcOk    = frmValid && portEnable[frmSrcPort];
        classHit = classMatch(ingressClass[frmSrcPort], frmBcast, frmMcast, frmFlood);
        ingOk    = !classHit || ingAllow[frmSrcPort];
        fwd      = frmDstMask & vlanAllow & portEnable & ~srcBit;
        if (!(srcOk && ingOk)) begin
            fwd = NO_PORTS;
        end
        fwdFinal   = fwd & egAllow;
        ingConsume = (srcOk && classHit && ingAllow[frmSrcPort]) ? srcBit : NO_PORTS;
        egConsume  = fwdFinal;
        rxCopy     = srcOk && mirrorRxSrc[frmSrcPort];
        txCopy     = (fwdFinal & mirrorTxSrc) != NO_PORTS;
        mirror     = NO_PORTS;
        if (rxCopy) begin
            mirror = mirror | portBit(mirrorRxDest);
        end
        if (txCopy) begin
            mirror = mirror | (mirrorSplit ? portBit(mirrorTxDest)
                                           : portBit(mirrorRxDest));
        end
        mirror = mirror & portEnable;
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            outValid      <= 1'b0;
            outFwdMask    <= NO_PORTS;
            outMirrorMask <= NO_PORTS;
            outDropped    <= 1'b0;
            vlanModeOut   <= VLAN_DISABLED;
        end else begin
            outValid      <= frmValid;
            outFwdMask    <= fwdFinal;
            outMirrorMask <= mirror;
            outDropped    <= frmValid && !(srcOk && ingOk);
            vlanModeOut   <= vlanMode_reg;
        end
    end
endmodule

// File: switch_policy_props.sv
// concurrent checks on the ports of the frame policy block
`timescale 1ns/1ps
module switch_policy_props
    import switch_policy_pkg::*;
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    // configuration and frames in
    input wire logic [NUM_PORTS-1:0]  portEnable,
    input wire logic [PORT_IDX_W-1:0] mirrorRxDest,
    input wire logic [NUM_PORTS-1:0]  mirrorRxSrc,
    input wire logic                  vlanModeWr,
    input wire logic [1:0]            vlanModeIn,
    input wire logic                  frmValid,
    input wire logic [PORT_IDX_W-1:0] frmSrcPort,
    input wire logic [NUM_PORTS-1:0]  frmDstMask,
    // decisions out
    input wire logic                  outValid,
    input wire logic [NUM_PORTS-1:0]  outFwdMask,
    input wire logic [NUM_PORTS-1:0]  outMirrorMask,
    input wire logic                  outDropped,
    input wire logic [1:0]            vlanModeOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // frame steps
    sequence s_frm;
        frmValid ##1 outValid;
    endsequence
    sequence s_src_off;
        frmValid && !portEnable[frmSrcPort];
    endsequence
    sequence s_rx_mon;
        frmValid && portEnable[frmSrcPort] && mirrorRxSrc[frmSrcPort] && portEnable[mirrorRxDest];
    endsequence
    a_out_follows: assert property (frmValid |-> s_frm)
        else $error("decision missing after frame");
    a_no_extra_out: assert property (!frmValid |=> !outValid)
        else $error("decision without frame");
    a_fwd_in_dst: assert property (frmValid |=>
        (outFwdMask & ~$past(frmDstMask)) == 8'h00)
        else $error("forward beyond normal egress set");
    a_src_off_drop: assert property (s_src_off |=> outDropped &&
        (outFwdMask | outMirrorMask) == 8'h00)
        else $error("disabled source not dropped");
    a_off_no_send: assert property (frmValid |=>
        ((outFwdMask | outMirrorMask) & ~$past(portEnable)) == 8'h00)
        else $error("disabled port sends");
    a_rx_copy: assert property (s_rx_mon |=> outMirrorMask[$past(mirrorRxDest)])
        else $error("rx copy missing");
    a_drop_empty: assert property (outDropped |-> outValid && outFwdMask == 8'h00)
        else $error("dropped frame forwarded");
    a_mode_load: assert property (vlanModeWr |-> ##2 vlanModeOut == $past(vlanModeIn, 2))
        else $error("vlan mode not loaded");
    a_mode_reset: assert property ($rose(rstn) |-> vlanModeOut == 2'h0)
        else $error("vlan mode not off after reset");
endmodule
bind switch_policy switch_policy_props chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .portEnable(portEnable), .mirrorRxDest(mirrorRxDest),
    .mirrorRxSrc(mirrorRxSrc), .vlanModeWr(vlanModeWr), .vlanModeIn(vlanModeIn),
    .frmValid(frmValid), .frmSrcPort(frmSrcPort), .frmDstMask(frmDstMask), .outValid(outValid),
    .outFwdMask(outFwdMask), .outMirrorMask(outMirrorMask), .outDropped(outDropped),
    .vlanModeOut(vlanModeOut)
);

// File: mirror_analyzer.sv
// analyzer model on the monitor ports counting mirror copies
`timescale 1ns/1ps
module mirror_analyzer
    import switch_policy_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // monitor traffic
    input  wire logic                 outValid,
    input  wire logic [NUM_PORTS-1:0] outMirrorMask,
    output logic      [15:0]          copyCount
);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            copyCount <= 16'h0000;
        end else if (outValid) begin
            copyCount <= copyCount + 16'($countones(outMirrorMask));
        end
    end
endmodule

// File: tb_top.sv
// self-checking bench for the frame policy block
`timescale 1ns/1ps
module tb_top;
    import switch_policy_pkg::*;
    typedef struct packed {logic [7:0] f; logic [7:0] m; logic d;} note_t;
    logic                   sys_clk, rstn, mirrorSplit, vlanModeWr, vlanGroupWr, vlanGroupValid;
    logic                   frmValid, frmBcast, frmMcast, frmFlood, frmTagged, outValid, outDropped;
    logic [2:0]             mirrorRxDest, mirrorTxDest, frmSrcPort;
    logic [7:0]             portEnable, mirrorRxSrc, mirrorTxSrc, vlanGroupId, vlanGroupMembers;
    logic [7:0]             frmDstMask, outFwdMask, outMirrorMask;
    logic [7:0][1:0]        ingressClass;
    logic [7:0][RATE_W-1:0] ingressRateKbps, egressRateKbps;
    logic [1:0]             vlanModeIn, vlanModeOut, mode;
    logic [LEN_W-1:0]       frmLenBytes;
    logic [15:0]            copyCount;
    logic [31:0]            seed;
    logic [7:0]             gm[256];
    logic                   gv[256];
    logic [3:0]             hit[4] = '{4'h0, 4'h1, 4'h2, 4'h4};
    int                     errors, total_checks, cyc, expCopies;
    note_t                  notes[$];
    switch_policy #(.TICK_CYCLES_P(10)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .portEnable(portEnable), .mirrorSplit(mirrorSplit),
        .mirrorRxDest(mirrorRxDest), .mirrorTxDest(mirrorTxDest), .mirrorRxSrc(mirrorRxSrc),
        .mirrorTxSrc(mirrorTxSrc), .ingressClass(ingressClass),
        .ingressRateKbps(ingressRateKbps), .egressRateKbps(egressRateKbps),
        .vlanModeWr(vlanModeWr), .vlanModeIn(vlanModeIn), .vlanGroupWr(vlanGroupWr),
        .vlanGroupId(vlanGroupId), .vlanGroupValid(vlanGroupValid),
        .vlanGroupMembers(vlanGroupMembers), .frmValid(frmValid), .frmSrcPort(frmSrcPort),
        .frmDstMask(frmDstMask), .frmBcast(frmBcast), .frmMcast(frmMcast), .frmFlood(frmFlood),
        .frmTagged(frmTagged), .frmLenBytes(frmLenBytes), .outValid(outValid),
        .outFwdMask(outFwdMask), .outMirrorMask(outMirrorMask), .outDropped(outDropped),
        .vlanModeOut(vlanModeOut));
    mirror_analyzer ana_u (.sys_clk(sys_clk), .rstn(rstn), .outValid(outValid),
        .outMirrorMask(outMirrorMask), .copyCount(copyCount));
    // ==========================================================
    // expected decision
    function automatic note_t expect_dec(input logic [2:0] s, input logic [7:0] dst,
                                         input logic lim, input logic [7:0] cut);
        logic [7:0] al, f, m;
        al = 8'hff;
        if (mode == 2'h1) begin
            al = 8'h00;
            foreach (gv[i]) if (gv[i] && gm[i][s]) al |= gm[i];
            if (al == 8'h00) begin
                al = 8'hff;
                foreach (gv[i]) if (gv[i]) al &= ~gm[i];
            end
        end
        f = (!portEnable[s] || lim) ? 8'h00 : dst & al & portEnable & ~(8'h01 << s) & ~cut;
        m = 8'h00;
        if (portEnable[s] && mirrorRxSrc[s]) m[mirrorRxDest] = 1'b1;
        if ((f & mirrorTxSrc) != 8'h00) begin
            m[mirrorSplit ? mirrorTxDest : mirrorRxDest] = 1'b1;
        end
        return '{f, m & portEnable, !portEnable[s] || lim};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ==========================================================
    // compare and drive
    task automatic fail(input string msg);
        errors++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic cmp_dec(input note_t e);
        total_checks++;
        if ({outFwdMask, outMirrorMask, outDropped} !== e) fail("frame decision");
    endtask
    task automatic cmp_mode(input logic [1:0] e);
        total_checks++;
        if (vlanModeOut !== e) fail("vlan mode");
    endtask
    task automatic cmp_copies();
        total_checks++;
        if (copyCount !== 16'(expCopies)) fail("mirror copy count");
    endtask
    task automatic frame(input logic [2:0] s, input logic [7:0] dst, input logic [3:0] ty,
                         input logic [10:0] len, input logic lim, input logic [7:0] cut);
        note_t e;
        @(posedge sys_clk);
        e = expect_dec(s, dst, lim, cut);
        notes.push_back(e);
        expCopies += $countones(e.m);
        frmValid <= 1'b1;
        frmSrcPort <= s;
        frmDstMask <= dst;
        {frmTagged, frmBcast, frmMcast, frmFlood} <= ty;
        frmLenBytes <= len;
    endtask
    task automatic rnd(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            frmValid <= 1'b0;
            seed = lfsr(seed);
            portEnable <= seed[7:0];
            {mirrorRxSrc, mirrorTxSrc} <= seed[23:8];
            {mirrorSplit, mirrorRxDest, mirrorTxDest} <= seed[30:24];
            seed = lfsr(seed);
            frame(seed[2:0], seed[10:3], seed[14:11], 11'h001, 1'b0, 8'h00);
        end
    endtask
    task automatic grp(input logic [7:0] id, input logic v, input logic [7:0] mem);
        @(posedge sys_clk);
        frmValid <= 1'b0;
        {vlanGroupWr, vlanGroupId, vlanGroupValid, vlanGroupMembers} <= {1'b1, id, v, mem};
        gv[id] = v;
        gm[id] = mem;
        @(posedge sys_clk);
        vlanGroupWr <= 1'b0;
    endtask
    task automatic set_mode(input logic [1:0] md);
        @(posedge sys_clk);
        frmValid <= 1'b0;
        vlanModeWr <= 1'b1;
        vlanModeIn <= md;
        mode = md;
        @(posedge sys_clk);
        vlanModeWr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        cmp_mode(md);
    endtask
    task automatic close_out();
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // clock, watcher, timeout
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail("timeout");
            close_out();
        end else if (outValid === 1'b1) begin
            if (notes.size() == 0) fail("unexpected decision");
            else cmp_dec(notes.pop_front());
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {rstn, mirrorSplit, vlanModeWr, vlanGroupWr, vlanGroupValid, frmValid} = 6'h00;
        {frmBcast, frmMcast, frmFlood, frmTagged, vlanModeIn, mode} = 8'h00;
        {mirrorRxDest, mirrorTxDest, frmSrcPort, vlanGroupId} = 17'h0c000;
        {portEnable, mirrorRxSrc, mirrorTxSrc} = 24'hff0800;
        {vlanGroupMembers, frmDstMask, frmLenBytes} = 27'h0000000;
        seed = 32'h82262484;
        for (int p = 0; p < 8; p++) begin
            ingressClass[p] = 2'(p);
            ingressRateKbps[p] = (p < 4) ? RATE_MIN_KBPS : RATE_OFF;
            egressRateKbps[p] = (p == 7) ? RATE_MIN_KBPS : RATE_OFF;
        end
        ingressRateKbps[4] = 18'h00001;
        foreach (gv[i]) {gv[i], gm[i]} = 9'h000;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        cmp_mode(2'h0);
        repeat (1300) @(posedge sys_clk);
        for (int p = 0; p < 4; p++) begin
            frame(3'(p), 8'h70, hit[p], 11'h5dc, 1'b0, 8'h00);
            frame(3'(p), 8'h70, hit[p], 11'h5dc, 1'b1, 8'h00);
            if (p > 0) frame(3'(p), 8'h70, hit[p-1], 11'h5dc, 1'b0, 8'h00);
        end
        frame(3'h4, 8'h01, 4'h0, 11'h5f5, 1'b0, 8'h00);
        frame(3'h4, 8'h01, 4'h0, 11'h5f5, 1'b1, 8'h00);
        frame(3'h7, 8'h01, 4'h0, 11'h5dc, 1'b0, 8'h00);
        frame(3'h5, 8'h80, 4'h4, 11'h5dc, 1'b0, 8'h00);
        frame(3'h5, 8'h80, 4'h0, 11'h5dc, 1'b0, 8'h80);
        rnd(60);
        grp(8'h05, 1'b1, 8'h33);
        grp(8'h09, 1'b1, 8'h46);
        grp(8'h07, 1'b0, 8'hff);
        grp(8'hff, 1'b1, 8'h04);
        foreach (hit[i]) begin
            set_mode(2'(i + 1));
            rnd(60);
        end
        @(posedge sys_clk);
        frmValid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmp_copies();
        if (notes.size() != 0) fail("decision missing");
        close_out();
    end
endmodule
